// >>> hw/prmd_pkg.sv
/*
  Constants and carrier types for the processor register move decoder.
  Assumes a 32-bit instruction word and 64-bit integer register data.
*/
// Overview of operation
// - five reserved opcodes map to special load, store, move-to, move-from, return.
// - special opcodes fault outside privileged mode unless enable bit permits kernel mode.
// - opcode 25 reads a processor register, opcode 29 writes one.
// - data moves between selected processor register and the named integer register.
// - three select bits pick banks; a write updates every selected bank in parallel.
// - all select bits zero makes the move a no-operation.
// - index selects the register within the bank per the fixed index map.
// - thirty-two privileged temporaries, reached only through these moves, index 31-00.
// - some accesses have side effects such as buffer invalidates or cache flush.
// - normal dependency checking and bypass apply to integer operands.
// - privileged mode runs privileged, untranslated fetch, interrupts off.
// - privileged mode still allows virtual and physical data references.
// - instruction buffer registers 0,1,3,6,7,8 only reachable in privileged mode.
// - exception entry takes pc bits 33..14 from base, 13..0 from offset.
package prmd_pkg;
  localparam int PRMD_XLEN = 64;
  localparam int PRMD_IDXW = 5;
  localparam int PRMD_NTEMP = 32;
  localparam logic [5:0] PRMD_OP_MFPR = 6'h19;
  localparam logic [5:0] PRMD_OP_LD = 6'h1b;
  localparam logic [5:0] PRMD_OP_MTPR = 6'h1d;
  localparam logic [5:0] PRMD_OP_REI = 6'h1e;
  localparam logic [5:0] PRMD_OP_ST = 6'h1f;
  localparam int PRMD_OPC_HI = 31;
  localparam int PRMD_OPC_LO = 26;
  localparam int PRMD_RA_HI = 25;
  localparam int PRMD_RA_LO = 21;
  localparam int PRMD_RB_HI = 20;
  localparam int PRMD_RB_LO = 16;
  localparam int PRMD_SEL_TEMP = 7;
  localparam int PRMD_SEL_ADDR = 6;
  localparam int PRMD_SEL_INSTR = 5;
  localparam int PRMD_IDX_HI = 4;
  localparam int PRMD_IDX_LO = 0;
  localparam int PRMD_HW_EN_BIT = 32;
  localparam int PRMD_PC_W = 34;
  localparam int PRMD_PC_SPLIT = 14;
  // instruction unit indices
  localparam logic [4:0] I_TAG = 5'h00;
  localparam logic [4:0] I_PTE = 5'h01;
  localparam logic [4:0] I_CSR = 5'h02;
  localparam logic [4:0] I_PTET = 5'h03;
  localparam logic [4:0] I_EXCA = 5'h04;
  localparam logic [4:0] I_SLR = 5'h05;
  localparam logic [4:0] I_ZAP = 5'h06;
  localparam logic [4:0] I_ASM = 5'h07;
  localparam logic [4:0] I_IS = 5'h08;
  localparam logic [4:0] I_PSTAT = 5'h09;
  localparam logic [4:0] I_ESUM = 5'h0a;
  localparam logic [4:0] I_BASE = 5'h0b;
  localparam logic [4:0] I_HWIRQ = 5'h0c;
  localparam logic [4:0] I_SWIRQ = 5'h0d;
  localparam logic [4:0] I_ATRQ = 5'h0e;
  localparam logic [4:0] I_HWIEN = 5'h10;
  localparam logic [4:0] I_SWIEN = 5'h11;
  localparam logic [4:0] I_ATEN = 5'h12;
  localparam logic [4:0] I_SLC = 5'h13;
  localparam logic [4:0] I_SLX = 5'h16;
  // address unit indices
  localparam logic [4:0] A_DCTL = 5'h00;
  localparam logic [4:0] A_PTE = 5'h02;
  localparam logic [4:0] A_PTET = 5'h03;
  localparam logic [4:0] A_MMSTAT = 5'h04;
  localparam logic [4:0] A_FVADDR = 5'h05;
  localparam logic [4:0] A_ZAP = 5'h06;
  localparam logic [4:0] A_ASM = 5'h07;
  localparam logic [4:0] A_IS = 5'h08;
  localparam logic [4:0] A_BADDR = 5'h09;
  localparam logic [4:0] A_BSTAT = 5'h0a;
  localparam logic [4:0] A_DADDR = 5'h0b;
  localparam logic [4:0] A_DSTAT = 5'h0c;
  localparam logic [4:0] A_FADDR = 5'h0d;
  localparam logic [4:0] A_ACTL = 5'h0e;
  localparam logic [4:0] A_ALT = 5'h0f;
  localparam logic [4:0] A_CYC = 5'h10;
  localparam logic [4:0] A_CCCTL = 5'h11;
  localparam logic [4:0] A_BCTL = 5'h12;
  localparam logic [4:0] A_FSYN = 5'h13;
  localparam logic [4:0] A_BCTAG = 5'h14;
  localparam logic [4:0] A_FLIC = 5'h15;
  localparam logic [4:0] A_FLICA = 5'h17;
  localparam logic [63:0] PRMD_ZERO = 64'h0;

  typedef struct packed {
    logic valid;
    logic [31:0] word;
    logic [63:0] src_data;
  } prmd_issue_t;

  typedef struct packed {
    logic itb_zap;
    logic itb_asm;
    logic itb_single;
    logic dtb_zap;
    logic dtb_asm;
    logic dtb_single;
    logic ic_flush;
    logic ic_flush_asm;
    logic sl_clear;
  } prmd_side_t;

  typedef struct packed {
    logic valid;
    logic [4:0] dest;
    logic [63:0] data;
  } prmd_result_t;
endpackage

// >>> hw/prmd_decoder.sv
/*
  Decoder and register banks for privileged register moves.
  Assumes the pipeline issues one instruction per valid cycle with its source
  operand already bypassed, and that status inputs are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module prmd_decoder
  import prmd_pkg::*;
#(
  parameter int XLEN = PRMD_XLEN,
  parameter int NTEMP = PRMD_NTEMP
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire prmd_issue_t issue_in,
  input wire logic priv_mode_in,
  input wire logic kernel_mode_in,
  input wire logic [63:0] abox_status_in [PRMD_NTEMP],
  input wire logic [63:0] ibox_status_in [PRMD_NTEMP],
  input wire logic exc_entry_in,
  input wire logic [13:0] exc_offset_in,
  output prmd_result_t result_out,
  output logic fault_out,
  output logic is_ld_out,
  output logic is_st_out,
  output logic is_rei_out,
  output logic [4:0] rd_reg_out,
  output prmd_side_t side_out,
  output logic [63:0] abox_wdata_out,
  output logic [PRMD_NTEMP-1:0] abox_we_out,
  output logic [PRMD_PC_W-1:0] entry_pc_out,
  output logic fetch_xlate_off_out,
  output logic intr_off_out,
  output logic all_priv_out,
  output logic dstream_ok_out
);
  logic [5:0] opc;
  logic [4:0] idx;
  logic sel_t, sel_a, sel_i;
  logic is_special, allowed, is_mf, is_mt, do_op;
  logic ipriv_only, iwr, ard;
  logic [63:0] temps [NTEMP];
  logic [63:0] ibank [NTEMP];
  logic [63:0] rd_val;
  logic [NTEMP-1:0] ibank_rw;

  assign opc = issue_in.word[PRMD_OPC_HI:PRMD_OPC_LO];
  assign idx = issue_in.word[PRMD_IDX_HI:PRMD_IDX_LO];
  assign sel_t = issue_in.word[PRMD_SEL_TEMP];
  assign sel_a = issue_in.word[PRMD_SEL_ADDR];
  assign sel_i = issue_in.word[PRMD_SEL_INSTR];
  // rb field equals ra by contract, ra used
  assign rd_reg_out = issue_in.word[PRMD_RA_HI:PRMD_RA_LO];
  assign is_special = issue_in.valid && (opc == PRMD_OP_MFPR || opc == PRMD_OP_MTPR ||
    opc == PRMD_OP_LD || opc == PRMD_OP_ST || opc == PRMD_OP_REI);
  assign allowed = priv_mode_in ||
    (kernel_mode_in && ibank[I_CSR][PRMD_HW_EN_BIT]);
  assign is_mf = is_special && opc == PRMD_OP_MFPR;
  assign is_mt = is_special && opc == PRMD_OP_MTPR;
  assign do_op = allowed;
  assign is_ld_out = is_special && opc == PRMD_OP_LD && allowed;
  assign is_st_out = is_special && opc == PRMD_OP_ST && allowed;
  assign is_rei_out = is_special && opc == PRMD_OP_REI && allowed;
  // priv-only instruction unit entries
  assign ipriv_only = idx == I_TAG || idx == I_PTE || idx == I_PTET ||
    idx == I_ZAP || idx == I_ASM || idx == I_IS;

  // which instruction-unit indices hold real read-write state
  always_comb begin
    ibank_rw = '0;
    ibank_rw[I_PTE] = 1'b1;
    ibank_rw[I_CSR] = 1'b1;
    ibank_rw[I_EXCA] = 1'b1;
    ibank_rw[I_PSTAT] = 1'b1;
    ibank_rw[I_ESUM] = 1'b1;
    ibank_rw[I_BASE] = 1'b1;
    ibank_rw[I_SWIRQ] = 1'b1;
    ibank_rw[I_ATRQ] = 1'b1;
    ibank_rw[I_HWIEN] = 1'b1;
    ibank_rw[I_SWIEN] = 1'b1;
    ibank_rw[I_ATEN] = 1'b1;
  end
  assign iwr = is_mt && do_op && sel_i && !(ipriv_only && !priv_mode_in);
  assign ard = !(idx == A_DCTL || idx == A_ZAP || idx == A_ASM || idx == A_IS ||
    idx == A_ACTL || idx == A_ALT || idx == A_CYC || idx == A_CCCTL ||
    idx == A_BCTL || idx == A_FLIC || idx == A_FLICA);

  // reserved-opcode fault, registered with the result
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fault_out <= 1'b0;
    end else begin
      fault_out <= is_special && !allowed;
    end
  end

  // temporaries: only reachable through these moves
  genvar g;
  generate
    for (g = 0; g < NTEMP; g++) begin : g_bank
      always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
          temps[g] <= PRMD_ZERO;
        end else if (is_mt && do_op && sel_t && idx == 5'(g)) begin
          temps[g] <= issue_in.src_data;
        end
      end
      // read-only entries follow their status input; writes never land there
      always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
          ibank[g] <= PRMD_ZERO;
        end else if (iwr && idx == 5'(g) && ibank_rw[g]) begin
          ibank[g] <= issue_in.src_data;
        end else if (!ibank_rw[g]) begin
          ibank[g] <= ibox_status_in[g];
        end
      end
      // abox banks live in the address unit; write strobes per index
      assign abox_we_out[g] = is_mt && do_op && sel_a && idx == 5'(g);
    end
  endgenerate
  assign abox_wdata_out = issue_in.src_data;

  // read mux: all selects zero gives nothing read
  always_comb begin
    rd_val = PRMD_ZERO;
    if (sel_t) begin
      rd_val = rd_val | temps[idx];
    end
    if (sel_a && ard) begin
      rd_val = rd_val | abox_status_in[idx];
    end
    if (sel_i && !(ipriv_only && !priv_mode_in)) begin
      rd_val = rd_val | ibank[idx];
    end
  end

  // result: writeback through normal bypass network
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_out <= '0;
    end else begin
      result_out.valid <= is_mf && do_op && (sel_t || sel_a || sel_i);
      result_out.dest <= issue_in.word[PRMD_RA_HI:PRMD_RA_LO];
      result_out.data <= rd_val;
    end
  end

  // side effects, one cycle pulse
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      side_out <= '0;
    end else begin
      side_out.itb_zap <= iwr && idx == I_ZAP;
      side_out.itb_asm <= iwr && idx == I_ASM;
      side_out.itb_single <= iwr && idx == I_IS;
      side_out.sl_clear <= iwr && idx == I_SLC;
      side_out.dtb_zap <= abox_we_out[A_ZAP];
      side_out.dtb_asm <= abox_we_out[A_ASM];
      side_out.dtb_single <= abox_we_out[A_IS];
      side_out.ic_flush <= abox_we_out[A_FLIC];
      side_out.ic_flush_asm <= abox_we_out[A_FLICA];
    end
  end

  // no interlock on these banks: spacing is the producer's job
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      entry_pc_out <= '0;
    end else if (exc_entry_in) begin
      entry_pc_out <= {ibank[I_BASE][PRMD_PC_W-1:PRMD_PC_SPLIT], exc_offset_in};
    end
  end

  assign all_priv_out = priv_mode_in;
  assign fetch_xlate_off_out = priv_mode_in;
  assign intr_off_out = priv_mode_in;
  assign dstream_ok_out = 1'b1;
endmodule
`default_nettype wire

// >>> test/prmd_decoder_sva.sv
/*
  port assertions for the register move decoder.
  assumes one clock domain with asynchronous low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module prmd_decoder_sva
  import prmd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire prmd_issue_t issue_in,
  input wire logic priv_mode_in,
  input wire logic kernel_mode_in,
  input wire logic exc_entry_in,
  input wire logic [13:0] exc_offset_in,
  input wire prmd_result_t result_out,
  input wire logic fault_out,
  input wire logic is_ld_out,
  input wire logic [4:0] rd_reg_out,
  input wire prmd_side_t side_out,
  input wire logic [PRMD_PC_W-1:0] entry_pc_out,
  input wire logic all_priv_out,
  input wire logic fetch_xlate_off_out,
  input wire logic intr_off_out,
  input wire logic dstream_ok_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  logic [5:0] op;
  logic [2:0] sel;
  logic mv;
  assign op = issue_in.word[31:26];
  assign sel = issue_in.word[7:5];
  assign mv = issue_in.valid && (op == PRMD_OP_MFPR || op == PRMD_OP_MTPR);
  a_fault_outside: assert property (mv && !priv_mode_in && !kernel_mode_in |=> fault_out)
    else $error("no fault outside privileged mode");
  a_priv_nofault: assert property (issue_in.valid && priv_mode_in |=> !fault_out)
    else $error("fault in privileged mode");
  a_env_follow: assert property (all_priv_out == priv_mode_in &&
    fetch_xlate_off_out == priv_mode_in && intr_off_out == priv_mode_in)
    else $error("mode outputs differ from mode");
  a_dstream_on: assert property (dstream_ok_out)
    else $error("data stream disabled");
  a_read_dest: assert property (mv && op == PRMD_OP_MFPR && priv_mode_in && sel != 3'h0
    |=> result_out.valid && result_out.dest == $past(issue_in.word[25:21]))
    else $error("read result missing or wrong dest");
  a_nop_quiet: assert property (mv && sel == 3'h0 |=> !result_out.valid && side_out == '0)
    else $error("nop move had effect");
  a_write_quiet: assert property (mv && op == PRMD_OP_MTPR |=> !result_out.valid)
    else $error("write produced a result");
  a_ld_strobe: assert property (issue_in.valid && op == PRMD_OP_LD && priv_mode_in
    |-> is_ld_out) else $error("load strobe missing");
  a_ibx_guard: assert property (mv && !priv_mode_in && sel == 3'b001 &&
    issue_in.word[4:0] == I_ZAP |=> !side_out.itb_zap) else $error("guarded side effect");
  a_entry_low: assert property (exc_entry_in |=> entry_pc_out[13:0] == $past(exc_offset_in))
    else $error("entry offset wrong");
  a_rd_field: assert property (rd_reg_out == issue_in.word[25:21])
    else $error("rd field wrong");
endmodule
bind prmd_decoder prmd_decoder_sva i_prmd_decoder_sva (.clk_sys_in, .nrst_in, .issue_in,
  .priv_mode_in, .kernel_mode_in, .exc_entry_in, .exc_offset_in, .result_out, .fault_out,
  .is_ld_out, .rd_reg_out, .side_out, .entry_pc_out, .all_priv_out, .fetch_xlate_off_out,
  .intr_off_out, .dstream_ok_out);
`default_nettype wire

// >>> test/prmd_pipe_model.sv
/*
  pipeline side: assembles move words for the decoder.
  fields come from the bench, changed at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module prmd_pipe_model
  import prmd_pkg::*;
(
  input wire logic go_in,
  input wire logic [5:0] op_in,
  input wire logic [2:0] sel_in,
  input wire logic [4:0] idx_in,
  input wire logic [4:0] ra_in,
  input wire logic [63:0] data_in,
  output prmd_issue_t issue_out
);
  always_comb begin
    issue_out.valid = go_in;
    issue_out.word = {op_in, ra_in, ra_in, 8'h00, sel_in, idx_in};
    // idle operand is scrambled so a stale value is never mistaken for data
    issue_out.src_data = go_in ? data_in : ~data_in;
  end
endmodule
`default_nettype wire

// >>> test/test_prmd_decoder.sv
/*
  self-checking bench for the register move decoder.
  assumes the pipeline model and the bound checker; moves are spaced by one idle cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module test_prmd_decoder
  import prmd_pkg::*;
;
  logic clk_sys_in = 1'b0, nrst_in, go, priv, kern, exc_en;
  logic [5:0] op;
  logic [2:0] sel, st_c;
  logic [4:0] idx, ra, rdr;
  logic [13:0] exc_off;
  logic [63:0] data, awd, wd_c;
  logic [63:0] abox_st [PRMD_NTEMP], ibox_st [PRMD_NTEMP];
  logic [31:0] awe, we_c;
  logic [33:0] epc;
  logic fault, isld, isst, isrei, fx, io, ap, ds;
  prmd_issue_t issue;
  prmd_result_t res;
  prmd_side_t side;
  integer seed = 32'he85ed87e, mismatches = 0, tests_run = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  prmd_pipe_model i_prmd_pipe_model (.go_in(go), .op_in(op), .sel_in(sel), .idx_in(idx),
    .ra_in(ra), .data_in(data), .issue_out(issue));
  prmd_decoder i_prmd_decoder (.clk_sys_in, .nrst_in, .issue_in(issue), .priv_mode_in(priv),
    .kernel_mode_in(kern), .abox_status_in(abox_st), .ibox_status_in(ibox_st),
    .exc_entry_in(exc_en), .exc_offset_in(exc_off), .result_out(res), .fault_out(fault),
    .is_ld_out(isld), .is_st_out(isst), .is_rei_out(isrei), .rd_reg_out(rdr),
    .side_out(side), .abox_wdata_out(awd), .abox_we_out(awe), .entry_pc_out(epc),
    .fetch_xlate_off_out(fx), .intr_off_out(io), .all_priv_out(ap), .dstream_ok_out(ds));
  function automatic logic [33:0] exp_pc(input logic [63:0] b, input logic [13:0] o);
    return {b[33:14], o};
  endfunction
  // side-effect pulses expected from a permitted write to both unit banks
  function automatic prmd_side_t exp_side(input logic [2:0] s, input logic [4:0] i);
    prmd_side_t e;
    e = '0;
    e.itb_zap = s[0] && i == I_ZAP;
    e.itb_asm = s[0] && i == I_ASM;
    e.itb_single = s[0] && i == I_IS;
    e.sl_clear = s[0] && i == I_SLC;
    e.dtb_zap = s[1] && i == A_ZAP;
    e.dtb_asm = s[1] && i == A_ASM;
    e.dtb_single = s[1] && i == A_IS;
    e.ic_flush = s[1] && i == A_FLIC;
    e.ic_flush_asm = s[1] && i == A_FLICA;
    return e;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // same-cycle strobes are captured before the taking edge
  task automatic mv(input logic [5:0] o, input logic [2:0] s, input logic [4:0] i,
    input logic [63:0] d);
    @(negedge clk_sys_in);
    {op, sel, idx, data, ra, go} = {o, s, i, d, 5'($random(seed)), 1'b1};
    #1;
    {we_c, wd_c, st_c} = {awe, awd, isld, isst, isrei};
    @(negedge clk_sys_in);
    go = 1'b0;
  endtask
  task automatic end_sim;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  initial begin
    logic [4:0] i;
    logic [63:0] d;
    logic [2:0] s;
    {go, exc_en, kern, priv, nrst_in, op, sel, idx, ra, data, exc_off} = '0;
    priv = 1'b1;
    for (int k = 0; k < PRMD_NTEMP; k++) begin
      abox_st[k] = {$random(seed), $random(seed)};
      ibox_st[k] = {$random(seed), $random(seed)};
    end
    repeat (8) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    chk({ap, fx, io, ds}, 4'hf);
    for (int n = 0; n < 12; n++) begin
      i = (n == 0) ? 5'h00 : (n == 1) ? 5'h1f : 5'($random(seed));
      d = {$random(seed), $random(seed)};
      mv(PRMD_OP_MTPR, 3'b100, i, d);
      mv(PRMD_OP_MFPR, 3'b100, i, 64'h0);
      chk(res.valid, 1);
      chk(res.dest, ra);
      chk(rdr, ra);
      chk(res.data, d);
    end
    d = {$random(seed), $random(seed)};
    mv(PRMD_OP_MTPR, 3'b101, I_SWIRQ, d);
    mv(PRMD_OP_MFPR, 3'b001, I_SWIRQ, 0);
    chk(res.data, d);
    mv(PRMD_OP_MFPR, 3'b100, I_SWIRQ, 0);
    chk(res.data, d);
    mv(PRMD_OP_MTPR, 3'b010, A_ACTL, d);
    chk(we_c, 32'h1 << A_ACTL);
    chk(wd_c, d);
    mv(PRMD_OP_MFPR, 3'b010, A_BADDR, 0);
    chk(res.data, abox_st[A_BADDR]);
    mv(PRMD_OP_MFPR, 3'b000, I_CSR, 0);
    chk(res.valid, 0);
    mv(PRMD_OP_MTPR, 3'b001, I_HWIRQ, d);
    mv(PRMD_OP_MFPR, 3'b001, I_HWIRQ, 0);
    chk(res.data, ibox_st[I_HWIRQ]);
    mv(PRMD_OP_MTPR, 3'b001, I_ZAP, 0);
    chk(side.itb_zap, 1);
    mv(PRMD_OP_MTPR, 3'b010, A_IS, 0);
    chk(side.dtb_single, 1);
    priv = 1'b0;
    mv(PRMD_OP_MFPR, 3'b100, 5'h01, 0);
    chk(fault, 1);
    mv(PRMD_OP_MTPR, 3'b010, A_ACTL, d);
    chk(we_c, 0);
    chk({ap, fx, io, ds}, 4'h1);
    kern = 1'b1;
    mv(PRMD_OP_MFPR, 3'b100, 5'h01, 0);
    chk(fault, 1);
    priv = 1'b1;
    mv(PRMD_OP_MTPR, 3'b001, I_CSR, 64'h1 << PRMD_HW_EN_BIT);
    priv = 1'b0;
    mv(PRMD_OP_MFPR, 3'b100, 5'h01, 0);
    chk(fault, 0);
    mv(PRMD_OP_MTPR, 3'b001, I_ZAP, 0);
    chk(side.itb_zap, 0);
    {priv, kern} = 2'b10;
    for (int k = 0; k < 3; k++) begin
      mv(k == 0 ? PRMD_OP_LD : k == 1 ? PRMD_OP_ST : PRMD_OP_REI, 3'b000, 5'h00, 0);
      chk(st_c, 3'b100 >> k);
    end
    // every index through both unit banks; the temporary bit is drawn at random
    for (int k = 0; k < PRMD_NTEMP; k++) begin
      s = 3'($random(seed)) | 3'b011;
      mv(PRMD_OP_MTPR, s, 5'(k), 64'h0);
      chk(side, exp_side(s, 5'(k)));
    end
    mv(PRMD_OP_MTPR, 3'b001, I_BASE, d);
    exc_off = 14'($random(seed));
    exc_en = 1'b1;
    @(negedge clk_sys_in);
    exc_en = 1'b0;
    chk(epc, exp_pc(d, exc_off));
    end_sim();
  end
endmodule
`default_nettype wire
